// *** design/quad_reload_down_timer.sv ***
`default_nettype none
// Operation
// - Four timers, each 8-bit presettable down counter
// - Two width bits join pairs into 16 bits
// - 8-bit mode: each timer controlled independently
// - 16-bit: low underflow clocks high timer
// - 16-bit pair governed by low timer controls
// - Clock select: 1, /4, /32, /256
// - Timer 0 may count event input pin
// - Reload registers read/write, cleared at reset
// - 16-bit reload: low timer low byte
// - Preset write copies reload into counter
// - 16-bit preset loads both; high preset ignored
// - Underflow reloads counter and keeps counting
// - Underflow requests interrupt and feeds clock out
// - Run 1 counts, run 0 gates clock
// - Start/stop never alters counter contents
// - 16-bit: low run bit; high run ignored
// - Divided clock routable to output pin
// - 16-bit: only high underflow raises interrupt
// - Underflow sets flag regardless of mask
// - Clock out toggles on selected underflow
module quad_reload_down_timer
  import quad_timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic event_input_pin_i,
  output logic clock_out_pin_o,
  output logic [NUM_TIMERS-1:0] underflow_irq_o
);
  // Registers
  logic ack_r;
  logic [DAT_W-1:0] rdata_r;
  logic [DAT_W-1:0] rdata_nxt;
  logic [CTRL_W-1:0] ctrl_r;
  logic [NUM_TIMERS-1:0] run_control_r;
  logic [NUM_TIMERS-1:0] run_nxt;
  logic [7:0] clock_divide_sel_r;
  logic [CNT_W-1:0] reload_value_r [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] underflow_irq_flag_r;
  logic [NUM_TIMERS-1:0] flag_nxt;
  logic [NUM_TIMERS-1:0] underflow_irq_enable_r;
  logic [7:0] pre_r;
  logic ev_s1_r;
  logic ev_s2_r;
  logic ev_s3_r;
  logic divided_clock_out_r;
  logic pin_r;

  // Decoded wires
  logic acc_w;
  logic wr_w;
  logic wr_ctrl_w;
  logic wr_run_w;
  logic wr_preset_w;
  logic wr_divsel_w;
  logic wr_flag_w;
  logic wr_enable_w;
  logic [NUM_TIMERS-1:0] wr_reload_w;
  logic [NUM_TIMERS-1:0] preset_strobe_w;
  logic [NUM_TIMERS-1:0] clear_w;
  logic [NUM_TIMERS-1:0] irq_set_w;
  logic [NUM_TIMERS-1:0] run_wmask_w;
  logic [NUM_TIMERS-1:0] tick_w;
  logic [NUM_TIMERS-1:0] run_eff_w;
  logic [NUM_TIMERS-1:0] load_w;
  logic [NUM_TIMERS-1:0] uf_w;
  logic [NUM_TIMERS-1:0] div_tick_w;
  logic [CNT_W-1:0] count_w [NUM_TIMERS];
  logic pair01_width_sel;
  logic pair23_width_sel;
  logic event_mode_w;
  logic out_en_w;
  logic [1:0] chsel_w;
  logic ev_edge_w;
  logic sel_uf_w;

  // Address match against one register
  function automatic logic hit(input logic [ADR_W-1:0] adr,
                               input logic [ADR_W-1:0] base);
    hit = (adr == base);
  endfunction

  // Count clock enable for one divide setting
  function automatic logic div_tick(input logic [1:0] sel,
                                    input logic [7:0] pre);
    logic [7:0] mask;
    mask = 8'h00;
    case (clock_divide_sel_t'(sel))
      DIV_4: mask = PRE_MASK_4;
      DIV_32: mask = PRE_MASK_32;
      DIV_256: mask = PRE_MASK_256;
      default: mask = 8'h00;
    endcase
    div_tick = ((pre & mask) == mask);
  endfunction

  // Control fields
  assign pair01_width_sel = ctrl_r[CTRL_PAIR01_BIT];
  assign pair23_width_sel = ctrl_r[CTRL_PAIR23_BIT];
  assign event_mode_w = ctrl_r[CTRL_EVENT_BIT];
  assign out_en_w = ctrl_r[CTRL_OUT_EN_BIT];
  assign chsel_w = ctrl_r[CTRL_CHSEL_LSB +: 2];

  // Bus decode; a write lands on the edge where ack is seen
  assign acc_w = wb_cyc_i & wb_stb_i;
  assign wr_w = acc_w & wb_we_i & ack_r & wb_sel_i[0];
  assign wr_ctrl_w = wr_w & hit(wb_adr_i, ADDR_CTRL);
  assign wr_run_w = wr_w & hit(wb_adr_i, ADDR_RUN);
  assign wr_preset_w = wr_w & hit(wb_adr_i, ADDR_PRESET);
  assign wr_divsel_w = wr_w & hit(wb_adr_i, ADDR_DIVSEL);
  assign wr_flag_w = wr_w & hit(wb_adr_i, ADDR_FLAG);
  assign wr_enable_w = wr_w & hit(wb_adr_i, ADDR_ENABLE);
  assign preset_strobe_w = wr_preset_w ? wb_dat_i[NUM_TIMERS-1:0] : '0;
  assign clear_w = wr_flag_w ? wb_dat_i[NUM_TIMERS-1:0] : '0;

  // High run bits of a joined pair are write protected
  assign run_wmask_w = ~{pair23_width_sel, 1'b0,
                         pair01_width_sel, 1'b0};
  assign run_nxt = (run_control_r & ~run_wmask_w) |
                   (wb_dat_i[NUM_TIMERS-1:0] & run_wmask_w);

  // Low timer of a joined pair raises no interrupt
  assign irq_set_w = uf_w & ~{1'b0, pair23_width_sel,
                              1'b0, pair01_width_sel};
  assign flag_nxt = (underflow_irq_flag_r & ~clear_w) | irq_set_w;
  assign underflow_irq_o = underflow_irq_flag_r &
                           underflow_irq_enable_r;

  // Event edge: falling edge of the synchronised pin
  assign ev_edge_w = ev_s3_r & ~ev_s2_r;
  assign sel_uf_w = uf_w[chsel_w];
  assign clock_out_pin_o = pin_r;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // Per-timer wiring of clock, run and preset
  genvar k;
  generate
    for (k = 0; k < NUM_TIMERS; k++) begin : g_ch
      timer_chan_if #(.W(CNT_W)) chan ();
      assign wr_reload_w[k] = wr_w &
        hit(wb_adr_i, ADDR_RELOAD0 + ADR_W'(k) * ADDR_STEP);
      assign div_tick_w[k] = div_tick(clock_divide_sel_r[2*k +: 2],
                                      pre_r);
      if (k == 0) begin : g_ev
        assign tick_w[k] = event_mode_w ? ev_edge_w
                                        : div_tick_w[k];
      end else if (k % 2 == 1) begin : g_hi
        logic joined;
        assign joined = (k == 1) ? pair01_width_sel : pair23_width_sel;
        assign tick_w[k] = joined ? uf_w[k-1] : div_tick_w[k];
        assign run_eff_w[k] = joined ? run_control_r[k-1]
                                     : run_control_r[k];
        assign load_w[k] = joined ? preset_strobe_w[k-1]
                                  : preset_strobe_w[k];
      end else begin : g_lo
        assign tick_w[k] = div_tick_w[k];
      end
      if (k % 2 == 0) begin : g_even
        assign run_eff_w[k] = run_control_r[k];
        assign load_w[k] = preset_strobe_w[k];
      end
      assign chan.tick = tick_w[k];
      assign chan.run = run_eff_w[k];
      assign chan.load = load_w[k];
      assign chan.reload = reload_value_r[k];
      assign count_w[k] = chan.count;
      assign uf_w[k] = chan.underflow;
      reload_down_counter #(.W(CNT_W)) u_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .port(chan.chan)
      );
    end
  endgenerate

  // Read data selection
  always_comb begin
    rdata_nxt = '0;
    if (hit(wb_adr_i, ADDR_CTRL)) begin
      rdata_nxt[CTRL_W-1:0] = ctrl_r;
    end else if (hit(wb_adr_i, ADDR_RUN)) begin
      rdata_nxt[NUM_TIMERS-1:0] = run_control_r;
    end else if (hit(wb_adr_i, ADDR_DIVSEL)) begin
      rdata_nxt[7:0] = clock_divide_sel_r;
    end else if (hit(wb_adr_i, ADDR_FLAG)) begin
      rdata_nxt[NUM_TIMERS-1:0] = underflow_irq_flag_r;
    end else if (hit(wb_adr_i, ADDR_ENABLE)) begin
      rdata_nxt[NUM_TIMERS-1:0] = underflow_irq_enable_r;
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (hit(wb_adr_i, ADDR_RELOAD0 + ADR_W'(i) * ADDR_STEP)) begin
          rdata_nxt[CNT_W-1:0] = reload_value_r[i];
        end else if (hit(wb_adr_i,
                         ADDR_COUNT0 + ADR_W'(i) * ADDR_STEP)) begin
          rdata_nxt[CNT_W-1:0] = count_w[i];
        end
      end
    end
  end

  // Bus answer: ack one cycle after the request is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= '0;
    end else if (ce_i) begin
      ack_r <= acc_w & ~ack_r;
      rdata_r <= (acc_w & ~ack_r) ? rdata_nxt : rdata_r;
    end
  end

  // Control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
      run_control_r <= RUN_RST;
      clock_divide_sel_r <= DIVSEL_RST;
      underflow_irq_enable_r <= ENABLE_RST;
    end else if (ce_i) begin
      if (wr_ctrl_w) ctrl_r <= wb_dat_i[CTRL_W-1:0] & CTRL_WMASK;
      if (wr_run_w) run_control_r <= run_nxt;
      if (wr_divsel_w) clock_divide_sel_r <= wb_dat_i[7:0];
      if (wr_enable_w) begin
        underflow_irq_enable_r <= wb_dat_i[NUM_TIMERS-1:0];
      end
    end
  end

  // Reload values
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (rst_i) begin
        reload_value_r[i] <= RELOAD_RST;
      end else if (ce_i && wr_reload_w[i]) begin
        reload_value_r[i] <= wb_dat_i[CNT_W-1:0];
      end
    end
  end

  // Flags, prescaler and event pin synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      underflow_irq_flag_r <= FLAG_RST;
      pre_r <= PRE_RST;
      ev_s1_r <= 1'b0;
      ev_s2_r <= 1'b0;
      ev_s3_r <= 1'b0;
    end else if (ce_i) begin
      underflow_irq_flag_r <= flag_nxt;
      pre_r <= pre_r + 8'h01;
      ev_s1_r <= event_input_pin_i;
      ev_s2_r <= ev_s1_r;
      ev_s3_r <= ev_s2_r;
    end
  end

  // Divided clock: toggle per selected underflow, pin high when off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      divided_clock_out_r <= 1'b0;
      pin_r <= 1'b1;
    end else if (ce_i) begin
      divided_clock_out_r <= divided_clock_out_r ^ sel_uf_w;
      pin_r <= ~out_en_w | divided_clock_out_r;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_reload_reset: assert property ($past(rst_i) |->
    reload_value_r[0] == 8'h00 && reload_value_r[3] == 8'h00)
    else $error("reload value not cleared by reset");
  a_preset_copy: assert property (ce_i && load_w[0] |=>
    count_w[0] == $past(reload_value_r[0]))
    else $error("preset did not copy reload value");
  a_pair_preset: assert property (ce_i && pair01_width_sel &&
    preset_strobe_w[0] |=> count_w[1] == $past(reload_value_r[1]))
    else $error("16-bit preset missed high byte");
  a_uf_reload: assert property (ce_i && uf_w[2] |=>
    count_w[2] == $past(reload_value_r[2]))
    else $error("underflow did not reload counter");
  a_count_step: assert property (ce_i && tick_w[3] && run_eff_w[3] &&
    !load_w[3] && count_w[3] != 8'h00 |=>
    count_w[3] == $past(count_w[3]) - 8'h01)
    else $error("counter did not step down");
  a_stop_hold: assert property (ce_i && !run_eff_w[0] && !load_w[0]
    |=> $stable(count_w[0]))
    else $error("stopped counter changed");
  a_hi_run_ign: assert property (ce_i && pair01_width_sel && wr_run_w
    |=> run_control_r[1] == $past(run_control_r[1]))
    else $error("high run bit written in 16-bit mode");
  a_chain_clock: assert property (pair23_width_sel |->
    tick_w[3] == uf_w[2] && run_eff_w[3] == run_control_r[2])
    else $error("high timer not clocked by low underflow");
  a_flag_set: assert property (ce_i && uf_w[1] |=>
    underflow_irq_flag_r[1])
    else $error("underflow flag not set");
  a_low_no_irq: assert property (ce_i && pair01_width_sel &&
    !underflow_irq_flag_r[0] |=> !underflow_irq_flag_r[0])
    else $error("low timer flag set in 16-bit mode");
  a_clk_toggle: assert property (ce_i && sel_uf_w |=>
    divided_clock_out_r != $past(divided_clock_out_r))
    else $error("clock out did not toggle");
  a_bus_ack: assert property (acc_w && !ack_r && ce_i |=> ack_r ##1 !ack_r)
    else $error("bus answer timing broken");

  c_pair_uf: cover property (pair01_width_sel && uf_w[1]);
  c_event_uf: cover property (event_mode_w && uf_w[0]);
  c_clk_out: cover property (out_en_w && sel_uf_w);
  c_set_clear: cover property (irq_set_w[3] && clear_w[3]);
endmodule
`default_nettype wire

// *** design/quad_timer_pkg.sv ***
`default_nettype none
package quad_timer_pkg;
  // Structure
  localparam int NUM_TIMERS = 4;
  localparam int CNT_W = 8;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RUN = 8'h04;
  localparam logic [7:0] ADDR_PRESET = 8'h08;
  localparam logic [7:0] ADDR_DIVSEL = 8'h0c;
  localparam logic [7:0] ADDR_RELOAD0 = 8'h10;
  localparam logic [7:0] ADDR_COUNT0 = 8'h20;
  localparam logic [7:0] ADDR_FLAG = 8'h30;
  localparam logic [7:0] ADDR_ENABLE = 8'h34;
  localparam logic [7:0] ADDR_STEP = 8'h04;

  // Control register fields
  localparam int CTRL_PAIR01_BIT = 0;
  localparam int CTRL_PAIR23_BIT = 1;
  localparam int CTRL_EVENT_BIT = 2;
  localparam int CTRL_OUT_EN_BIT = 3;
  localparam int CTRL_CHSEL_LSB = 4;
  localparam int CTRL_W = 6;
  localparam logic [5:0] CTRL_WMASK = 6'h3f;

  // Reset values
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [7:0] DIVSEL_RST = 8'h00;
  localparam logic [3:0] RUN_RST = 4'h0;
  localparam logic [3:0] FLAG_RST = 4'h0;
  localparam logic [3:0] ENABLE_RST = 4'h0;
  localparam logic [7:0] PRE_RST = 8'h00;

  // Prescaler masks: tick when masked bits are all ones
  localparam logic [7:0] PRE_MASK_4 = 8'h03;
  localparam logic [7:0] PRE_MASK_32 = 8'h1f;
  localparam logic [7:0] PRE_MASK_256 = 8'hff;

  // Count clock selection, encoding as the 2-bit field
  typedef enum logic [1:0] {
    DIV_1,
    DIV_4,
    DIV_32,
    DIV_256
  } clock_divide_sel_t;
endpackage
`default_nettype wire

// *** design/timer_chan_if.sv ***
`default_nettype none
// One timer channel: control side drives tick, run, load, reload
interface timer_chan_if #(parameter int W = 8);
  logic tick;
  logic run;
  logic load;
  logic [W-1:0] reload;
  logic [W-1:0] count;
  logic underflow;
  modport ctrl (output tick, run, load, reload, input count, underflow);
  modport chan (input tick, run, load, reload, output count, underflow);
endinterface
`default_nettype wire

// *** design/reload_down_counter.sv ***
`default_nettype none
module reload_down_counter #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  timer_chan_if.chan port
);
  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic step_w;
  logic zero_w;

  // Counting only with run and a count clock; preset takes priority
  assign step_w = port.tick & port.run & ~port.load;
  assign zero_w = (count_r == '0);
  assign port.underflow = step_w & zero_w;
  assign port.count = count_r;

  // Next count: preset, reload on underflow, or decrement
  always_comb begin
    count_nxt = count_r;
    if (port.load) begin
      count_nxt = port.reload;
    end else if (step_w && zero_w) begin
      count_nxt = port.reload;
    end else if (step_w) begin
      count_nxt = count_r - W'(1);
    end
  end

  // Counter register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= '0;
    end else if (ce_i) begin
      count_r <= count_nxt;
    end
  end
endmodule
`default_nettype wire

// *** bench/test_quad_reload_down_timer.sv ***
`default_nettype none
module test_quad_reload_down_timer import quad_timer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [ADR_W-1:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [DAT_W-1:0] wb_dat_i = 32'h0;
  logic [DAT_W-1:0] wb_dat_o;
  logic wb_ack_o;
  logic event_input_pin_i = 1'b1;
  logic clock_out_pin_o;
  logic [NUM_TIMERS-1:0] underflow_irq_o;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] q;
  logic [31:0] q1;
  int n;

  quad_reload_down_timer quad_reload_down_timer_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .event_input_pin_i(event_input_pin_i),
    .clock_out_pin_o(clock_out_pin_o), .underflow_irq_o(underflow_irq_o)
  );

  // 10 MHz clock
  always #50 clk_i = ~clk_i;

  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // Classic single Wishbone cycle, held until ack is sampled
  task automatic acc(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    acc(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    acc(1'b0, a, 32'h0, r);
  endtask

  // Cycles between two changes of the clock output, after settling
  task automatic per(output int c);
    logic p;
    c = 0;
    repeat (2) begin
      @(posedge clk_i);
      p = clock_out_pin_o;
      do @(posedge clk_i); while (clock_out_pin_o === p);
    end
    p = clock_out_pin_o;
    do begin
      @(posedge clk_i);
      c++;
    end while (clock_out_pin_o === p);
  endtask

  // Reload registers: reset value, read back, unmapped read
  task automatic t_regs();
    for (int k = 0; k < 4; k++) begin
      rd(ADDR_RELOAD0 + 8'(k * 4), q);
      chk(q, 32'h0);
      wr(ADDR_RELOAD0 + 8'(k * 4), 32'h5a + 32'(k));
      rd(ADDR_RELOAD0 + 8'(k * 4), q);
      chk(q, 32'h5a + 32'(k));
    end
    rd(8'hfc, q);
    chk(q, 32'h0);
  endtask

  // Preset, then underflow period for every divide select
  task automatic t_div();
    wr(ADDR_CTRL, 32'h08);
    wr(ADDR_RELOAD0, 32'h03);
    wr(ADDR_PRESET, 32'h1);
    rd(ADDR_COUNT0, q);
    chk(q, 32'h03);
    wr(ADDR_RUN, 32'h1);
    for (int d = 0; d < 4; d++) begin
      wr(ADDR_DIVSEL, 32'(d));
      per(n);
      chk(32'(n), 32'(4 * (d == 0 ? 1 : d == 1 ? 4 : d == 2 ? 32 : 256)));
    end
    wr(ADDR_RUN, 32'h0);
    wr(ADDR_DIVSEL, 32'h0);
  endtask

  // Timer 1 alone: stop holds the count, restart continues
  task automatic t_hold();
    wr(ADDR_RELOAD0 + 8'h04, 32'h40);
    wr(ADDR_PRESET, 32'h3);
    wr(ADDR_RUN, 32'h2);
    repeat (10) @(posedge clk_i);
    wr(ADDR_RUN, 32'h0);
    rd(ADDR_COUNT0 + 8'h04, q1);
    chk(32'(q1 < 32'h40), 32'h1);
    repeat (10) @(posedge clk_i);
    rd(ADDR_COUNT0 + 8'h04, q);
    chk(q, q1);
    rd(ADDR_COUNT0, q);
    chk(q, 32'h03);
    wr(ADDR_RUN, 32'h2);
    wr(ADDR_RUN, 32'h0);
    rd(ADDR_COUNT0 + 8'h04, q);
    chk(32'(q < q1 && q > q1 - 32'h10), 32'h1);
  endtask

  // Joined pair 0/1: preset, ignored high bits, period, flags
  task automatic t_pair();
    wr(ADDR_CTRL, 32'h19);
    wr(ADDR_RELOAD0, 32'hff);
    wr(ADDR_RELOAD0 + 8'h04, 32'h01);
    wr(ADDR_PRESET, 32'h1);
    rd(ADDR_COUNT0, q);
    chk(q, 32'hff);
    rd(ADDR_COUNT0 + 8'h04, q);
    chk(q, 32'h01);
    wr(ADDR_RELOAD0 + 8'h04, 32'h03);
    wr(ADDR_PRESET, 32'h2);
    rd(ADDR_COUNT0 + 8'h04, q);
    chk(q, 32'h01);
    wr(ADDR_RUN, 32'h2);
    repeat (5) @(posedge clk_i);
    rd(ADDR_COUNT0, q);
    chk(q, 32'hff);
    wr(ADDR_RELOAD0 + 8'h04, 32'h01);
    wr(ADDR_PRESET, 32'h1);
    wr(ADDR_FLAG, 32'hf);
    wr(ADDR_RUN, 32'h1);
    per(n);
    chk(32'(n), 32'd512);
    rd(ADDR_FLAG, q);
    chk(q & 32'h3, 32'h2);
    wr(ADDR_RUN, 32'h0);
    wr(ADDR_CTRL, 32'h0);
  endtask

  // Timer 0 counts falling edges of the event pin
  task automatic t_event();
    wr(ADDR_CTRL, 32'h04);
    wr(ADDR_RELOAD0, 32'h03);
    wr(ADDR_PRESET, 32'h1);
    wr(ADDR_RUN, 32'h1);
    repeat (2) begin
      @(posedge clk_i);
      event_input_pin_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      event_input_pin_i <= 1'b1;
      repeat (6) @(posedge clk_i);
    end
    rd(ADDR_COUNT0, q);
    chk(q, 32'h01);
    wr(ADDR_RUN, 32'h0);
    wr(ADDR_CTRL, 32'h0);
  endtask

  // Flag set while masked, request only when enabled, clear
  task automatic t_flag();
    wr(ADDR_FLAG, 32'hf);
    wr(ADDR_RELOAD0 + 8'h08, 32'h00);
    wr(ADDR_PRESET, 32'h4);
    wr(ADDR_RUN, 32'h4);
    repeat (4) @(posedge clk_i);
    chk(32'(underflow_irq_o), 32'h0);
    rd(ADDR_FLAG, q);
    chk(q & 32'h4, 32'h4);
    wr(ADDR_ENABLE, 32'h4);
    @(posedge clk_i);
    chk(32'(underflow_irq_o), 32'h4);
    wr(ADDR_RUN, 32'h0);
    wr(ADDR_FLAG, 32'h4);
    rd(ADDR_FLAG, q);
    chk(q, 32'h0);
    @(posedge clk_i);
    chk(32'(underflow_irq_o), 32'h0);
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_div();
    t_hold();
    t_pair();
    t_event();
    t_flag();
    complete_run();
  end
endmodule
`default_nettype wire
